/* File: verilog/bec_composer.sv */
// bank-4 machine-check error code composer with avalon-mm register slave
`include "bec_consts.svh"

// Overview of operation
// - cache way code in bits 18:16; 000/100 none, 001/010/011 multi-way.
// - way code 101 one corr, 110 one uncorr, 111 corr and uncorr.
// - code in 31:16; cache type has 20:19 zero, 31:21 fixed pattern.
// - bus bits 16 request parity, 17/18 core address parity.
// - bits 20 response, 21 inbound data, 22/23 core data parity.
// - bit 24 flags deferred-reply info parity, either phase.
// - bit 25 flags inbound bus data ecc, correctable or not.
// - bit 26 data strobe glitch, bit 27 request strobe glitch.
// - bus error logs exactly one defined type-B bit.
// - inbound ecc class in uncorrected flag; syndrome if correctable.
// - all other bus errors logged uncorrectable.
// - inclusion errors 0001H core0, 0002H core1, 0005H bus.
// - write-exclusive errors 0003H core0, 0004H core1.
// - snoop stall 0006H, write stall 0007H, arb 0008H, queue 0009H.
// - thermal 0100H, timeouts 0200H/0300H, protected cache 0400H.
// - correctable outgoing ecc C001H bus, C002H core0, C004H core1.
// - uncorrectable outgoing ecc E001H, E002H, E004H; others reserved.
// - controller codes except correctable ecc logged uncorrected.
// - correctable controller ecc may carry syndrome in other info.
// - generic bits 15:0 select type C, A or B code.
// - bit 61 set when not corrected, clear when corrected.
// - syndrome in bits 51:44, bit 52 set when supplied.
module bec_composer
    import bec_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // cache way event
    input wire logic cache_evt,
    input wire logic [7:0] way_corr,
    input wire logic [7:0] way_uc,
    input wire logic [7:0] way_tag_hit,
    // bus and interconnect event
    input wire logic bus_evt,
    input wire logic [3:0] bus_src,
    input wire logic bus_ecc_uc,
    input wire logic bus_syn_valid,
    input wire logic [7:0] bus_syn,
    // cache-bus-controller event
    input wire logic cbc_evt,
    input wire logic [4:0] cbc_code,
    input wire logic cbc_syn_valid,
    input wire logic [7:0] cbc_syn,
    // logged status
    output logic [63:0] machine_check_bank4_status,
    output logic status_logged
);

    // more than one way set in a per-way report
    function automatic logic more_than_one(input logic [7:0] v);
        more_than_one = |(v & (v - 8'h01));
    endfunction : more_than_one

    // cache way code from per-way reports
    // mixed reports dominate; a lone tag hit is not an error
    // single-way, multi-way and mixed codes
    function automatic logic [2:0] way_code(
        input logic [7:0] corr,
        input logic [7:0] uc,
        input logic [7:0] tag
    );
        logic multi_c;
        logic multi_u;
        logic multi_t;
        multi_c = more_than_one(corr);
        multi_u = more_than_one(uc);
        multi_t = more_than_one(tag);
        if ((|corr) && (|uc))
            way_code = `BEC_WAY_MIXED;
        else if (multi_u)
            way_code = `BEC_WAY_MULTI_UC;
        else if (|uc)
            way_code = `BEC_WAY_ONE_UC;
        else if (multi_c)
            way_code = `BEC_WAY_MULTI_CORR;
        else if (|corr)
            way_code = `BEC_WAY_ONE_CORR;
        else if (multi_t)
            way_code = `BEC_WAY_MULTI_TAG;
        else
            way_code = `BEC_WAY_NONE;
    endfunction : way_code

    // bus source to model-specific code, zero if undefined
    function automatic logic [15:0] bus_code(input logic [3:0] src);
        case (src)
            BEC_B_REQ_PAR: bus_code = 16'h0001;
            BEC_B_ADDR0_PAR: bus_code = 16'h0002;
            BEC_B_ADDR1_PAR: bus_code = 16'h0004;
            BEC_B_RESP_PAR: bus_code = 16'h0010;
            BEC_B_DATA_PAR: bus_code = 16'h0020;
            BEC_B_CORE0_PAR: bus_code = 16'h0040;
            BEC_B_CORE1_PAR: bus_code = 16'h0080;
            BEC_B_DEFER_PAR: bus_code = 16'h0100;
            BEC_B_DATA_ECC: bus_code = 16'h0200;
            BEC_B_DSTB_GLITCH: bus_code = 16'h0400;
            BEC_B_RSTB_GLITCH: bus_code = 16'h0800;
            default: bus_code = 16'h0000;
        endcase
    endfunction : bus_code

    // controller event to code, zero for reserved indices
    function automatic logic [15:0] cbc_map(input logic [4:0] evt);
        case (evt)
            BEC_E_INCL_CORE0: cbc_map = `BEC_C_INCL_CORE0;
            BEC_E_INCL_CORE1: cbc_map = `BEC_C_INCL_CORE1;
            BEC_E_WREX_CORE0: cbc_map = `BEC_C_WREX_CORE0;
            BEC_E_WREX_CORE1: cbc_map = `BEC_C_WREX_CORE1;
            BEC_E_INCL_BUS: cbc_map = `BEC_C_INCL_BUS;
            BEC_E_SNOOP_STALL: cbc_map = `BEC_C_SNOOP_STALL;
            BEC_E_WR_STALL: cbc_map = `BEC_C_WR_STALL;
            BEC_E_ARB_TMO: cbc_map = `BEC_C_ARB_TMO;
            BEC_E_OOQ: cbc_map = `BEC_C_OOQ;
            BEC_E_THERMAL: cbc_map = `BEC_C_THERMAL;
            BEC_E_TMO_A: cbc_map = `BEC_C_TMO_A;
            BEC_E_TMO_B: cbc_map = `BEC_C_TMO_B;
            BEC_E_PCACHE: cbc_map = `BEC_C_PCACHE;
            BEC_E_CECC_BUS: cbc_map = `BEC_C_CECC_BUS;
            BEC_E_CECC_CORE0: cbc_map = `BEC_C_CECC_CORE0;
            BEC_E_CECC_CORE1: cbc_map = `BEC_C_CECC_CORE1;
            BEC_E_UECC_BUS: cbc_map = `BEC_C_UECC_BUS;
            BEC_E_UECC_CORE0: cbc_map = `BEC_C_UECC_CORE0;
            BEC_E_UECC_CORE1: cbc_map = `BEC_C_UECC_CORE1;
            default: cbc_map = 16'h0000;
        endcase
    endfunction : cbc_map

    // registers
    bec_bus_st_t bus_st_q;
    bec_bus_st_t bus_st_d;
    logic waitreq_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [63:0] status_q;
    logic [63:0] status_d;
    logic logged_q;
    logic logged_d;
    logic en_q;
    logic [7:0] drop_q;
    logic [7:0] drop_d;

    // type A composition
    wire [2:0] a_way = way_code(way_corr, way_uc, way_tag_hit);
    wire a_ok = cache_evt && (a_way != `BEC_WAY_NONE);
    wire [15:0] a_model_specific_error_code = {`BEC_A_PATTERN, `BEC_A_RSVD, a_way};
    // one uncorrectable way makes the whole event uncorrected
    wire a_uc = |way_uc;

    // type B composition
    // one type-B bit per defined bus source
    wire [15:0] b_model_specific_error_code = bus_code(bus_src);
    // undefined sources leave no bit, never logged
    wire b_ok = bus_evt && (b_model_specific_error_code != 16'h0000);
    wire b_is_ecc = (bus_src == BEC_B_DATA_ECC);
    wire b_uc = !b_is_ecc || bus_ecc_uc;
    wire b_syn = b_is_ecc && !bus_ecc_uc && bus_syn_valid;

    // type C composition
    // controller codes for every defined event
    wire [15:0] c_model_specific_error_code = cbc_map(cbc_code);
    // reserved codes map to zero and are not logged
    wire c_ok = cbc_evt && (c_model_specific_error_code != 16'h0000);
    wire c_corr = (cbc_code == BEC_E_CECC_BUS) ||
        (cbc_code == BEC_E_CECC_CORE0) || (cbc_code == BEC_E_CECC_CORE1);
    wire c_uc = !c_corr;
    wire c_syn = c_corr && cbc_syn_valid;

    // selection: bus over controller over cache when simultaneous
    // one status word holds one event; the others are lost
    wire any_ok = a_ok || b_ok || c_ok;
    wire sel_b = b_ok;
    wire sel_c = !b_ok && c_ok;
    wire [15:0] sel_type = sel_b ? `BEC_TYPE_B_CODE :
        (sel_c ? `BEC_TYPE_C_CODE : `BEC_TYPE_A_CODE);
    wire [15:0] sel_model_specific_error_code = sel_b ? b_model_specific_error_code : (sel_c ? c_model_specific_error_code : a_model_specific_error_code);
    wire sel_uc = sel_b ? b_uc : (sel_c ? c_uc : a_uc);
    wire sel_syn_v = sel_b ? b_syn : (sel_c ? c_syn : 1'b0);
    wire [7:0] sel_syn = sel_b ? bus_syn : cbc_syn;
    wire [7:0] syn_field = sel_syn_v ? sel_syn : 8'h00;
    wire log_now = any_ok && en_q;
    wire drop_full = (drop_q == 8'hFF);

    // bus slave decode
    // status is read-only; only the control register takes writes
    wire req = avs_read || avs_write;
    wire acc = (bus_st_q == BEC_BUS_ACK);
    wire wr_ctrl = acc && avs_write && (avs_address == `BEC_OFS_CTRL);
    wire wr_en = wr_ctrl && avs_byteenable[0];
    wire wr_clr = wr_ctrl && avs_byteenable[0] &&
        avs_writedata[`BEC_CTRL_CLR_BIT];
    wire hit_lo = (avs_address == `BEC_OFS_STATUS_LO);
    wire hit_hi = (avs_address == `BEC_OFS_STATUS_HI);
    wire hit_ctrl = (avs_address == `BEC_OFS_CTRL);
    wire hit_info = (avs_address == `BEC_OFS_INFO);

    // handshake: one wait cycle, one ack cycle, one release cycle
    // the release cycle lets the master drop its request before the
    // slave looks again, so a held request is never taken twice
    always_comb
    begin
        case (bus_st_q)
            BEC_BUS_IDLE: bus_st_d = req ? BEC_BUS_ACK : BEC_BUS_IDLE;
            BEC_BUS_ACK: bus_st_d = BEC_BUS_DONE;
            BEC_BUS_DONE: bus_st_d = BEC_BUS_IDLE;
            default: bus_st_d = BEC_BUS_IDLE;
        endcase
    end

    // read data frozen for the ack cycle
    // 64-bit status is not read atomically; disable logging first
    always_comb
    begin
        rdata_d = rdata_q;
        if (bus_st_q == BEC_BUS_IDLE && avs_read)
        begin
            if (hit_lo)
                rdata_d = status_q[31:0];
            else if (hit_hi)
                rdata_d = status_q[63:32];
            else if (hit_ctrl)
                rdata_d = {31'h0, en_q};
            else if (hit_info)
                rdata_d = {23'h0, drop_q, logged_q};
            // unmapped addresses read as zero
            else
                rdata_d = 32'h0;
        end
    end

    // capture; a new event wins over a clear in the same cycle
    // limitation: a corrected event may overwrite an uncorrected one
    always_comb
    begin
        status_d = status_q;
        logged_d = logged_q;
        if (wr_clr)
        begin
            status_d = 64'h0;
            logged_d = 1'b0;
        end
        if (log_now)
        begin
            status_d = 64'h0;
            status_d[15:0] = sel_type;
            status_d[`BEC_MODEL_SPECIFIC_ERROR_CODE_LSB +: 16] = sel_model_specific_error_code;
            status_d[`BEC_SYN_LSB +: 8] = syn_field;
            status_d[`BEC_SYN_VALID_BIT] = sel_syn_v;
            status_d[`BEC_UC_BIT] = sel_uc;
            logged_d = 1'b1;
        end
    end

    // events lost while logging is disabled, saturating
    always_comb
    begin
        drop_d = drop_q;
        if (wr_clr)
            drop_d = 8'h00;
        if (any_ok && !en_q && !drop_full)
            drop_d = drop_q + 8'h01;
    end

    // waitrequest registered so the port comes from a flip-flop
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bus_st_q <= BEC_BUS_IDLE;
            waitreq_q <= 1'b1;
            rdata_q <= 32'h0;
        end
        else
        begin
            bus_st_q <= bus_st_d;
            waitreq_q <= (bus_st_d != BEC_BUS_ACK);
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            status_q <= 64'h0;
            logged_q <= 1'b0;
            drop_q <= 8'h00;
        end
        else
        begin
            status_q <= status_d;
            logged_q <= logged_d;
            drop_q <= drop_d;
        end
    end

    // logging stays on out of reset so early errors are kept
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            en_q <= `BEC_CTRL_EN_RST;
        else if (wr_en)
            en_q <= avs_writedata[`BEC_CTRL_EN_BIT];
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = waitreq_q;
    assign machine_check_bank4_status = status_q;
    assign status_logged = logged_q;

endmodule : bec_composer

/* File: verilog/bec_consts.svh */
// offsets, field positions, encodings and reset values of the composer
`ifndef BEC_CONSTS_SVH
`define BEC_CONSTS_SVH

// register byte offsets on the avalon slave
`define BEC_OFS_STATUS_LO 4'h0
`define BEC_OFS_STATUS_HI 4'h4
`define BEC_OFS_CTRL 4'h8
`define BEC_OFS_INFO 4'hC

// control register fields and reset value
`define BEC_CTRL_EN_BIT 0
`define BEC_CTRL_CLR_BIT 1
`define BEC_CTRL_EN_RST 1'h1

// generic error-code values, status bits 15:0
`define BEC_TYPE_A_CODE 16'h010B
`define BEC_TYPE_B_CODE 16'h0E0F
`define BEC_TYPE_C_CODE 16'h0400

// cache way code
`define BEC_WAYS 8
`define BEC_WAY_NONE 3'h0
`define BEC_WAY_MULTI_CORR 3'h1
`define BEC_WAY_MULTI_UC 3'h2
`define BEC_WAY_MULTI_TAG 3'h3
`define BEC_WAY_ONE_CORR 3'h5
`define BEC_WAY_ONE_UC 3'h6
`define BEC_WAY_MIXED 3'h7
`define BEC_A_PATTERN 11'h100
`define BEC_A_RSVD 2'h0

// status field positions
`define BEC_MODEL_SPECIFIC_ERROR_CODE_LSB 16
`define BEC_SYN_LSB 44
`define BEC_SYN_VALID_BIT 52
`define BEC_UC_BIT 61

// cache-bus-controller model-specific codes
`define BEC_C_INCL_CORE0 16'h0001
`define BEC_C_INCL_CORE1 16'h0002
`define BEC_C_WREX_CORE0 16'h0003
`define BEC_C_WREX_CORE1 16'h0004
`define BEC_C_INCL_BUS 16'h0005
`define BEC_C_SNOOP_STALL 16'h0006
`define BEC_C_WR_STALL 16'h0007
`define BEC_C_ARB_TMO 16'h0008
`define BEC_C_OOQ 16'h0009
`define BEC_C_THERMAL 16'h0100
`define BEC_C_TMO_A 16'h0200
`define BEC_C_TMO_B 16'h0300
`define BEC_C_PCACHE 16'h0400
`define BEC_C_CECC_BUS 16'hC001
`define BEC_C_CECC_CORE0 16'hC002
`define BEC_C_CECC_CORE1 16'hC004
`define BEC_C_UECC_BUS 16'hE001
`define BEC_C_UECC_CORE0 16'hE002
`define BEC_C_UECC_CORE1 16'hE004

`endif

/* File: verilog/bec_pkg.sv */
// types shared by the bank-4 error code composer
package bec_pkg;

    // bus and interconnect sources, each mapped by bus_code to one type-B bit
    typedef enum logic [3:0] {
        BEC_B_REQ_PAR = 4'h0,
        BEC_B_ADDR0_PAR = 4'h1,
        BEC_B_ADDR1_PAR = 4'h2,
        BEC_B_RESP_PAR = 4'h3,
        BEC_B_DATA_PAR = 4'h4,
        BEC_B_CORE0_PAR = 4'h5,
        BEC_B_CORE1_PAR = 4'h6,
        BEC_B_DEFER_PAR = 4'h7,
        BEC_B_DATA_ECC = 4'h8,
        BEC_B_DSTB_GLITCH = 4'h9,
        BEC_B_RSTB_GLITCH = 4'hA
    } bec_bus_src_t;

    // cache-bus-controller events
    typedef enum logic [4:0] {
        BEC_E_INCL_CORE0 = 5'h00,
        BEC_E_INCL_CORE1 = 5'h01,
        BEC_E_WREX_CORE0 = 5'h02,
        BEC_E_WREX_CORE1 = 5'h03,
        BEC_E_INCL_BUS = 5'h04,
        BEC_E_SNOOP_STALL = 5'h05,
        BEC_E_WR_STALL = 5'h06,
        BEC_E_ARB_TMO = 5'h07,
        BEC_E_OOQ = 5'h08,
        BEC_E_THERMAL = 5'h09,
        BEC_E_TMO_A = 5'h0A,
        BEC_E_TMO_B = 5'h0B,
        BEC_E_PCACHE = 5'h0C,
        BEC_E_CECC_BUS = 5'h0D,
        BEC_E_CECC_CORE0 = 5'h0E,
        BEC_E_CECC_CORE1 = 5'h0F,
        BEC_E_UECC_BUS = 5'h10,
        BEC_E_UECC_CORE0 = 5'h11,
        BEC_E_UECC_CORE1 = 5'h12
    } bec_cbc_evt_t;

    // avalon slave handshake states
    typedef enum logic [1:0] {
        BEC_BUS_IDLE = 2'b00,
        BEC_BUS_ACK = 2'b01,
        BEC_BUS_DONE = 2'b10
    } bec_bus_st_t;

endpackage : bec_pkg

/* File: dv/bec_chk_assertions.sv */
// concurrent checks on the ports of the error code composer
module bec_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // register bus
    input wire logic [3:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    // events
    input wire logic cache_evt,
    input wire logic [7:0] way_corr,
    input wire logic [7:0] way_uc,
    input wire logic bus_evt,
    input wire logic [3:0] bus_src,
    input wire logic bus_ecc_uc,
    input wire logic bus_syn_valid,
    input wire logic [7:0] bus_syn,
    input wire logic cbc_evt,
    input wire logic [4:0] cbc_code,
    // status
    input wire logic [63:0] machine_check_bank4_status,
    input wire logic status_logged
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic en_q;
    wire [63:0] st = machine_check_bank4_status;
    wire ctl_wr = avs_write && !avs_waitrequest && avs_address == 4'h8;
    // mirror of the logging enable, since it is not a port
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            en_q <= 1'b1;
        else if (ctl_wr && avs_byteenable[0])
            en_q <= avs_writedata[0];
    end
    wire bus_ok = bus_evt && en_q && bus_src <= 4'hA;
    wire cbc_ok = cbc_evt && en_q && cbc_code <= 5'h12 && !bus_ok;
    wire cache_ok = cache_evt && en_q && (|way_corr || |way_uc)
        && !bus_ok && !cbc_ok;
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence s_logged;
        ##1 status_logged;
    endsequence
    a_ack_pulse: assert property ($fell(avs_waitrequest) |-> s_ack)
        else $error("waitrequest low longer than one cycle");
    a_bus_logged: assert property (bus_ok |-> s_logged)
        else $error("bus event not logged");
    a_bus_onehot: assert property (
        bus_ok |=> $onehot(st[27:16]) && st[15:0] == 16'h0E0F)
        else $error("bus code not one-hot");
    a_bus_rsvd: assert property (
        bus_ok |=> st[19] == 1'b0 && st[31:28] == 4'h0)
        else $error("bus reserved bits set");
    a_bus_uc: assert property (
        bus_ok && bus_src != 4'h8 |=> st[61])
        else $error("bus error not uncorrected");
    a_ecc_class: assert property (
        bus_ok && bus_src == 4'h8 |=> st[25] && st[61] == $past(bus_ecc_uc))
        else $error("inbound ecc class wrong");
    a_syn_place: assert property (
        bus_ok && bus_src == 4'h8 && !bus_ecc_uc && bus_syn_valid
        |=> st[52] && st[51:44] == $past(bus_syn))
        else $error("syndrome misplaced");
    a_cache_fixed: assert property (
        cache_ok |=> st[31:19] == {11'h100, 2'h0} && st[15:0] == 16'h010B)
        else $error("cache pattern wrong");
    a_cache_mixed: assert property (
        cache_ok && |way_corr && |way_uc |=> st[18:16] == 3'h7)
        else $error("mixed way code wrong");
    a_cache_uc: assert property (
        cache_ok |=> st[61] == ($past(way_uc) != 8'h0))
        else $error("cache uncorrected flag wrong");
    a_cbc_class: assert property (
        cbc_ok |=> st[15:0] == 16'h0400
        && st[61] == ($past(cbc_code) < 5'h0D || $past(cbc_code) > 5'h0F))
        else $error("controller class wrong");
    a_cbc_cecc: assert property (
        cbc_ok && cbc_code == 5'h0D |=> st[31:16] == 16'hC001)
        else $error("controller ecc code wrong");
endmodule : bec_chk

bind bec_composer bec_chk u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
    .cache_evt(cache_evt), .way_corr(way_corr), .way_uc(way_uc),
    .bus_evt(bus_evt), .bus_src(bus_src), .bus_ecc_uc(bus_ecc_uc),
    .bus_syn_valid(bus_syn_valid), .bus_syn(bus_syn), .cbc_evt(cbc_evt),
    .cbc_code(cbc_code), .status_logged(status_logged),
    .machine_check_bank4_status(machine_check_bank4_status)
);

/* File: dv/tb_top.sv */
// self-checking bench for the bank-4 error code composer
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address, avs_byteenable, bus_src;
    logic [31:0] avs_writedata, avs_readdata, seed;
    logic cache_evt, bus_evt, bus_ecc_uc, bus_syn_valid, cbc_evt;
    logic cbc_syn_valid, status_logged, evt_d, en, lg;
    logic [7:0] way_corr, way_uc, way_tag_hit, bus_syn, cbc_syn, drops;
    logic [4:0] cbc_code;
    logic [63:0] st, mdl;
    logic [64:0] exp_q[$];
    logic [31:0] rd_q[$];
    int n_mismatch, n_compared, i;
    logic [4:0] bpos [11] = '{5'h0, 5'h1, 5'h2, 5'h4, 5'h5, 5'h6, 5'h7,
        5'h8, 5'h9, 5'hA, 5'hB};
    logic [15:0] ctab [19] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004,
        16'h0005, 16'h0006, 16'h0007, 16'h0008, 16'h0009, 16'h0100,
        16'h0200, 16'h0300, 16'h0400, 16'hC001, 16'hC002, 16'hC004,
        16'hE001, 16'hE002, 16'hE004};

    bec_composer u_dut (
        .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cache_evt(cache_evt), .way_corr(way_corr), .way_uc(way_uc),
        .way_tag_hit(way_tag_hit), .bus_evt(bus_evt), .bus_src(bus_src),
        .bus_ecc_uc(bus_ecc_uc), .bus_syn_valid(bus_syn_valid),
        .bus_syn(bus_syn), .cbc_evt(cbc_evt), .cbc_code(cbc_code),
        .cbc_syn_valid(cbc_syn_valid), .cbc_syn(cbc_syn),
        .machine_check_bank4_status(st), .status_logged(status_logged)
    );

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic print_verdict;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [64:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    function automatic logic [2:0] way_code(logic [7:0] c, u, t);
        if (c != 8'h0 && u != 8'h0) return 3'h7;
        if ($countones(u) > 1) return 3'h2;
        if (u != 8'h0) return 3'h6;
        if ($countones(c) > 1) return 3'h1;
        if (c != 8'h0) return 3'h5;
        if ($countones(t) > 1) return 3'h3;
        return 3'h0;
    endfunction : way_code

    // outputs read at the rising edge, before that edge updates them
    always @(posedge mclk) evt_d <= cache_evt | bus_evt | cbc_evt;
    always @(posedge mclk)
    begin
        if (evt_d === 1'b1)
            chk("status", exp_q.pop_front(), {status_logged, st});
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            chk("readdata", {33'h0, rd_q.pop_front()}, {33'h0, avs_readdata});
    end

    task automatic rw(input logic wr, input logic [3:0] a,
        input logic [31:0] d, e);
        int n;
        @(posedge mclk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        if (!wr)
            rd_q.push_back(e);
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
        begin
            n_mismatch++;
            print_verdict();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (wr && a == 4'h8 && avs_byteenable[0])
        begin
            en = d[0];
            if (d[1])
                {mdl, lg, drops} = '0;
        end
    endtask : rw

    task automatic fire(input logic c, b, k, input logic [3:0] s,
        input logic [4:0] cc);
        logic [7:0] wc, wu, wt, sy;
        logic eu, bv, ce, ok;
        wc = $urandom & $urandom & $urandom;
        wu = $urandom & $urandom & $urandom;
        wt = $urandom;
        sy = $urandom;
        eu = $urandom % 4 == 0;
        bv = $urandom % 4 != 0;
        ce = cc inside {5'h0D, 5'h0E, 5'h0F};
        ok = (b && s <= 4'hA) || (k && cc <= 5'h12) ||
            (c && way_code(wc, wu, wt) != 3'h0);
        if (!en)
            drops = drops + 8'(ok && drops != 8'hFF);
        else if (b && s <= 4'hA)
        begin
            mdl = 64'h0E0F;
            mdl[16 + bpos[s]] = 1'b1;
            mdl[61] = !(s == 4'h8 && !eu);
            if (s == 4'h8 && !eu && bv)
                mdl[52:44] = {1'b1, sy};
            lg = 1'b1;
        end
        else if (k && cc <= 5'h12)
        begin
            mdl = {2'h0, !ce, 29'h0, ctab[cc], 16'h0400};
            if (ce && bv)
                mdl[52:44] = {1'b1, sy};
            lg = 1'b1;
        end
        else if (c && way_code(wc, wu, wt) != 3'h0)
        begin
            mdl = {2'h0, wu != 8'h0, 29'h0, 11'h100, 2'h0,
                way_code(wc, wu, wt), 16'h010B};
            lg = 1'b1;
        end
        @(posedge mclk);
        cache_evt <= c;
        bus_evt <= b;
        cbc_evt <= k;
        bus_src <= s;
        cbc_code <= cc;
        bus_ecc_uc <= eu;
        way_corr <= wc;
        way_uc <= wu;
        way_tag_hit <= wt;
        bus_syn <= sy;
        cbc_syn <= sy;
        bus_syn_valid <= bv;
        cbc_syn_valid <= bv;
        exp_q.push_back({lg, mdl});
    endtask : fire

    task automatic idle;
        @(posedge mclk);
        cache_evt <= 1'b0;
        bus_evt <= 1'b0;
        cbc_evt <= 1'b0;
    endtask : idle

    initial
    begin
        {sys_rst, avs_byteenable} = 5'h1F;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        {cache_evt, bus_evt, cbc_evt, bus_src, cbc_code, bus_ecc_uc} = '0;
        {way_corr, way_uc, way_tag_hit, bus_syn, cbc_syn} = '0;
        {bus_syn_valid, cbc_syn_valid, evt_d, lg, mdl, drops} = '0;
        en = 1'b1;
        seed = $urandom(32'hB003E57C);
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        rw(0, 4'h8, 0, 32'h1);
        rw(0, 4'hC, 0, 32'h0);
        rw(0, 4'h2, 0, 32'h0);
        for (i = 0; i < 19; i++)
            fire(0, 0, 1, 4'h0, 5'(i));
        for (i = 0; i < 64; i++)
            fire(0, 1, 0, 4'(i), 5'h0);
        for (i = 0; i < 300; i++)
        begin
            fire(i % 3 == 0, i % 3 == 1, i % 3 == 2, 4'($urandom),
                5'($urandom));
            if ($urandom % 2)
                idle();
        end
        fire(1, 1, 1, 4'h3, 5'h05);
        fire(1, 0, 1, 4'h0, 5'h0D);
        idle();
        rw(0, 4'h0, 0, mdl[31:0]);
        rw(0, 4'h4, 0, mdl[63:32]);
        rw(1, 4'h0, 32'hFFFFFFFF, 0);
        rw(0, 4'h0, 0, mdl[31:0]);
        rw(1, 4'h8, 32'h0, 0);
        fire(0, 1, 0, 4'h1, 5'h0);
        fire(0, 0, 1, 4'h0, 5'h03);
        idle();
        rw(0, 4'hC, 0, {23'h0, drops, lg});
        avs_byteenable <= 4'hE;
        rw(1, 4'h8, 32'h3, 0); // lane 0 off: ignored
        rw(0, 4'h8, 0, 32'h0);
        avs_byteenable <= 4'hF;
        rw(1, 4'h8, 32'h3, 0);
        rw(0, 4'h0, 0, 32'h0);
        rw(0, 4'hC, 0, 32'h0);
        rw(0, 4'h8, 0, 32'h1);
        print_verdict();
    end
endmodule : tb_top
